// ### design/tcsf_pkg.sv
//------------------------------------------------------------
// Overview of operation
// - External trigger sets flag until status read
// - Capture B load flag, capture mode only
// - Capture A load flag, capture mode only
// - C compare flag in both modes
// - B compare flag, waveform mode only
// - A compare flag, waveform mode only
// - Second unread capture load sets overrun flag
// - Counter overflow flag until status read
//------------------------------------------------------------
package tcsf_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_MASK = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_MODE = 4'h8;
  // Status bit positions
  localparam int BIT_COVF = 0;
  localparam int BIT_LOVR = 1;
  localparam int BIT_CPA = 2;
  localparam int BIT_CPB = 3;
  localparam int BIT_CPC = 4;
  localparam int BIT_LDRA = 5;
  localparam int BIT_LDRB = 6;
  localparam int BIT_ETRG = 7;
  localparam int FLAG_W = 8;
  // Reset values
  localparam logic [FLAG_W-1:0] RST_STATUS = 8'h00;
  localparam logic [FLAG_W-1:0] RST_MASK = 8'h00;
  localparam logic RST_WAVE = 1'b0;
endpackage

// ### design/tcsf_overrun.sv
`timescale 1ns/1ps
module tcsf_overrun (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_load,
  input wire logic i_reg_read,
  output logic o_overrun
);
  typedef struct packed {
    logic unread;
  } tcsf_ovr_state_t;
  tcsf_ovr_state_t st;
  tcsf_ovr_state_t next_st;
  logic ovr;
  // Overrun when a load finds the previous value still unread
  always_comb begin
    next_st = st;
    ovr = i_load & st.unread;
    if (i_load) begin
      next_st.unread = 1'b1;
    end else if (i_reg_read) begin
      next_st.unread = 1'b0;
    end
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_overrun = ovr;
endmodule

// ### design/tcsf_flag.sv
`timescale 1ns/1ps
module tcsf_flag (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_set,
  input wire logic i_clear,
  output logic o_flag
);
  typedef struct packed {
    logic flag;
  } tcsf_flag_state_t;
  tcsf_flag_state_t st;
  tcsf_flag_state_t next_st;
  // Set wins over clear so no event is dropped
  always_comb begin
    next_st = st;
    if (i_set) begin
      next_st.flag = 1'b1;
    end else if (i_clear) begin
      next_st.flag = 1'b0;
    end
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_flag = st.flag;
endmodule

// ### design/tcsf_status.sv
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module tcsf_status (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [tcsf_pkg::ADDR_W-1:0] i_addr,
  input wire logic [tcsf_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [tcsf_pkg::DATA_W-1:0] o_rdata,
  output logic o_irq,
  output logic o_waveform_mode_select,
  input wire logic i_ext_trigger,
  input wire logic i_load_a,
  input wire logic i_load_b,
  input wire logic i_read_reg_a,
  input wire logic i_read_reg_b,
  input wire logic i_match_a,
  input wire logic i_match_b,
  input wire logic i_match_c,
  input wire logic i_overflow
);
  localparam int FW = tcsf_pkg::FLAG_W;

  //------------------------------------------------------------
  // State
  //------------------------------------------------------------
  typedef struct packed {
    logic [FW-1:0] mask;
    logic wave;
    logic [tcsf_pkg::DATA_W-1:0] rdata;
  } tcsf_state_t;
  tcsf_state_t st;
  tcsf_state_t next_st;

  logic [FW-1:0] set_vec;
  logic [FW-1:0] flags;
  logic status_rd;
  logic ovr_a;
  logic ovr_b;

  function automatic logic hit(input logic [tcsf_pkg::ADDR_W-1:0] a,
                               input logic [tcsf_pkg::ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // Mode-exclusive flags read as zero in the other mode; stored bit kept
  function automatic logic [FW-1:0] visible(input logic [FW-1:0] f,
                                            input logic wave);
    logic [FW-1:0] m;
    m = '1;
    if (wave) begin
      m[tcsf_pkg::BIT_LDRB] = 1'b0;
      m[tcsf_pkg::BIT_LDRA] = 1'b0;
      m[tcsf_pkg::BIT_LOVR] = 1'b0;
    end else begin
      m[tcsf_pkg::BIT_CPB] = 1'b0;
      m[tcsf_pkg::BIT_CPA] = 1'b0;
    end
    visible = f & m;
  endfunction

  assign status_rd = i_rd & hit(i_addr, tcsf_pkg::OFS_STATUS);

  //------------------------------------------------------------
  // Overrun detection per capture register
  //------------------------------------------------------------
  tcsf_overrun u_ovr_a (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(i_load_a & ~st.wave),
    .i_reg_read(i_read_reg_a),
    .o_overrun(ovr_a)
  );
  tcsf_overrun u_ovr_b (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(i_load_b & ~st.wave),
    .i_reg_read(i_read_reg_b),
    .o_overrun(ovr_b)
  );

  //------------------------------------------------------------
  // Event gating by mode
  //------------------------------------------------------------
  always_comb begin
    set_vec = '0;
    set_vec[tcsf_pkg::BIT_ETRG] = i_ext_trigger;
    set_vec[tcsf_pkg::BIT_LDRB] = i_load_b & ~st.wave;
    set_vec[tcsf_pkg::BIT_LDRA] = i_load_a & ~st.wave;
    set_vec[tcsf_pkg::BIT_CPC] = i_match_c;
    set_vec[tcsf_pkg::BIT_CPB] = i_match_b & st.wave;
    set_vec[tcsf_pkg::BIT_CPA] = i_match_a & st.wave;
    set_vec[tcsf_pkg::BIT_LOVR] = ovr_a | ovr_b;
    set_vec[tcsf_pkg::BIT_COVF] = i_overflow;
  end

  // Flags cleared only by a status read
  genvar g;
  generate
    for (g = 0; g < FW; g++) begin : g_flag
      tcsf_flag u_flag (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_set(set_vec[g]),
        .i_clear(status_rd),
        .o_flag(flags[g])
      );
    end
  endgenerate

  //------------------------------------------------------------
  // Register bus
  //------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rdata = '0;
    if (i_wr) begin
      if (hit(i_addr, tcsf_pkg::OFS_MASK)) begin
        next_st.mask = i_wdata[FW-1:0];
      end else if (hit(i_addr, tcsf_pkg::OFS_MODE)) begin
        next_st.wave = i_wdata[0];
      end
    end
    if (i_rd) begin
      case (i_addr)
        tcsf_pkg::OFS_STATUS: begin
          next_st.rdata = {{(tcsf_pkg::DATA_W-FW){1'b0}}, visible(flags, st.wave)};
        end
        tcsf_pkg::OFS_MASK: next_st.rdata = {{(tcsf_pkg::DATA_W-FW){1'b0}}, st.mask};
        tcsf_pkg::OFS_MODE: next_st.rdata = {{(tcsf_pkg::DATA_W-1){1'b0}}, st.wave};
        default: next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st.mask <= tcsf_pkg::RST_MASK;
      st.wave <= tcsf_pkg::RST_WAVE;
      st.rdata <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  // Interrupt follows what software would read, not the stored bits
  assign o_irq = |(visible(flags, st.wave) & st.mask);
  assign o_waveform_mode_select = st.wave;
endmodule

// ### dv/tcsf_checker.sv
`timescale 1ns/1ps
module tcsf_checker (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [tcsf_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_rd,
  input wire logic [tcsf_pkg::DATA_W-1:0] o_rdata,
  input wire logic o_waveform_mode_select,
  input wire logic i_ext_trigger,
  input wire logic i_load_a,
  input wire logic i_load_b,
  input wire logic i_read_reg_a,
  input wire logic i_match_a,
  input wire logic i_match_b,
  input wire logic i_match_c,
  input wire logic i_overflow
);
  logic rs;
  logic w;
  assign rs = i_rd && i_addr == tcsf_pkg::OFS_STATUS;
  assign w = o_waveform_mode_select;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ----------------------------------------
  // Flag set, hold and clear
  // ----------------------------------------
  ext_flag_a: assert property (i_ext_trigger ##1 rs |=> o_rdata[7])
    else $error("trigger flag lost");
  load_b_a: assert property (i_load_b && !w ##1 rs && !w |=> o_rdata[6])
    else $error("load b flag lost");
  load_a_a: assert property (i_load_a && !w ##1 rs && !w |=> o_rdata[5])
    else $error("load a flag lost");
  cmp_c_a: assert property (i_match_c ##1 rs |=> o_rdata[4])
    else $error("compare c flag lost");
  cmp_b_a: assert property (i_match_b && w ##1 rs && w |=> o_rdata[3])
    else $error("compare b flag lost");
  cmp_a_a: assert property (i_match_a && w ##1 rs && w |=> o_rdata[2])
    else $error("compare a flag lost");
  cap_zero_a: assert property (rs && !w |=> o_rdata[3:2] == 2'h0)
    else $error("compare flag in capture mode");
  wave_zero_a: assert property (rs && w |=> o_rdata[6:5] == 2'h0 && !o_rdata[1])
    else $error("capture flag in waveform mode");
  overrun_a: assert property (i_load_a && !w ##1 i_load_a && !i_read_reg_a && !w ##1 rs && !w
    |=> o_rdata[1]) else $error("overrun missed");
  ovf_set_a: assert property (i_overflow ##1 rs |=> o_rdata[0])
    else $error("overflow flag lost");
  ovf_clear_a: assert property (rs && !i_overflow ##1 rs |=> !o_rdata[0])
    else $error("overflow flag not cleared");
  read_keep_a: assert property (rs && i_ext_trigger ##1 rs |=> o_rdata[7])
    else $error("event lost at read");
  cover property (rs && i_ext_trigger);
  cover property (i_load_a && !w ##1 i_load_a);
  cover property (rs ##1 rs);
endmodule

// ### dv/test_timer_channel_status_flags.sv
`timescale 1ns/1ps
module test_timer_channel_status_flags;
  logic i_clk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, o_irq, o_waveform_mode_select;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata, er = 32'h0, r;
  logic [8:0] ev = 9'h0;
  logic [7:0] fl, mk, nw;
  logic wv, ua, ub;
  int n_fail = 0, n_checks = 0, seed = 32'h2036;
  always #25 i_clk = ~i_clk;
  tcsf_status uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_waveform_mode_select(o_waveform_mode_select), .i_ext_trigger(ev[7]), .i_load_b(ev[6]),
    .i_load_a(ev[5]), .i_match_c(ev[4]), .i_match_b(ev[3]), .i_match_a(ev[2]),
    .i_read_reg_a(ev[1]), .i_overflow(ev[0]), .i_read_reg_b(ev[8]));
  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  // Mode-exclusive bits read as zero
  function automatic logic [7:0] vis(logic [7:0] f, logic m);
    return f & (m ? 8'h9d : 8'hf3);
  endfunction
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      {fl, mk, wv, ua, ub, er} = '0;
    end else begin
      nw = {ev[7], ev[6] && !wv, ev[5] && !wv, ev[4], ev[3] && wv, ev[2] && wv,
        !wv && (ev[5] && ua || ev[6] && ub), ev[0]};
      er = !i_rd ? 0 : i_addr == 0 ? vis(fl, wv) : i_addr == 4 ? mk : i_addr == 8 ? wv : 0;
      // Set wins over the read clear
      fl = (i_rd && i_addr == 0 ? 8'h0 : fl) | nw;
      ua = !wv && ev[5] || ua && !ev[1];
      ub = !wv && ev[6] || ub && !ev[8];
      if (i_wr && i_addr == 4) mk = i_wdata[7:0];
      if (i_wr && i_addr == 8) wv = i_wdata[0];
    end
  end
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  // Checked mid-cycle so the edge updates have landed
  always @(negedge i_clk) begin
    if (!i_sys_rst) begin
      chk("rdata", er, o_rdata);
      chk("irq", 32'((vis(fl, wv) & mk) != 0), 32'(o_irq));
      chk("mode", 32'(wv), 32'(o_waveform_mode_select));
    end
  end
  task automatic report_and_stop;
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Random traffic, never read and write together
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 0;
    // One reset pulse mid-run
    for (int i = 0; i < 4000; i++) begin
      @(posedge i_clk);
      r = $random(seed);
      i_sys_rst <= (i == 2000);
      ev <= $random(seed) & $random(seed);
      i_addr <= {r[1:0], 2'h0};
      i_rd <= r[3:2] == 2'h0;
      i_wr <= r[4:2] == 3'h7;
      i_wdata <= $random(seed);
    end
    report_and_stop();
  end
  initial begin
    #(5000 * 50);
    n_fail++;
    report_and_stop();
  end
endmodule
bind tcsf_status tcsf_checker u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_waveform_mode_select(o_waveform_mode_select),
  .i_ext_trigger(i_ext_trigger), .i_load_a(i_load_a), .i_load_b(i_load_b),
  .i_read_reg_a(i_read_reg_a), .i_match_a(i_match_a), .i_match_b(i_match_b),
  .i_match_c(i_match_c), .i_overflow(i_overflow));
